//--- hdl/sacv_pkg.sv
// Function
// [RULE_01] two sigma-delta channels, 24-bit, 128x oversampling
// [RULE_02] power register bits 3/2 enable left/right
// [RULE_03] software mutes a channel before disabling it
// [RULE_04] converter clock runs only with system clock enable
// [RULE_05] converter rate follows sample rate and ratio; here only the ratio field sets the period, rate is stored only
// [RULE_06] gain 0.375*(X-192) dB, code zero mutes
// [RULE_07] gain spans -71.625 to +23.625 dB
// [RULE_08] volume writes held until commit
// [RULE_09] commit bit 8 applies both gains together
// [RULE_10] left volume bits 7:0 at 15h, reset C0h
// [RULE_11] right volume bits 7:0 at 16h, same reset
// [RULE_12] both gains change on same sample frame
package sacv_pkg;

   // ==========================================================
   // register indexes, byte address is four times the index
   // ==========================================================
   localparam logic [7:0] SACV_IDX_CLK    = 8'h08;
   localparam logic [7:0] SACV_IDX_LVOL   = 8'h15;
   localparam logic [7:0] SACV_IDX_RVOL   = 8'h16;
   localparam logic [7:0] SACV_IDX_PWR    = 8'h19;
   localparam logic [7:0] SACV_IDX_STAT   = 8'h1A;
   localparam int         SACV_AW         = 10;

   // ==========================================================
   // field positions and reset values
   // ==========================================================
   localparam int         SACV_VOL_LSB    = 0;
   localparam int         SACV_VU_BIT     = 8;
   localparam int         SACV_LEN_BIT    = 3;
   localparam int         SACV_REN_BIT    = 2;
   localparam int         SACV_SYSEN_BIT  = 0;
   localparam int         SACV_RATE_LSB   = 4;
   localparam int         SACV_RATIO_LSB  = 8;
   localparam int         SACV_APPL_LSB   = 0;
   localparam int         SACV_APPR_LSB   = 8;
   localparam int         SACV_PEND_BIT   = 16;
   localparam logic [7:0] SACV_VOL_RST    = 8'hC0;

   // ==========================================================
   // converter figures
   // ==========================================================
   localparam int         SACV_SW         = 24;
   localparam logic [6:0] SACV_OSR_LAST   = 7'h7F;
   localparam logic [7:0] SACV_OSR_FULL   = 8'h80;
   localparam logic [7:0] SACV_MID        = 8'h40;

   typedef struct packed {
      logic [7:0]        lvol;
      logic [7:0]        rvol;
      logic [7:0]        lapp;
      logic [7:0]        rapp;
      logic              pend;
      logic              len;
      logic              ren;
      logic              sysen;
      logic [3:0]        rate;
      logic [2:0]        ratio;
      logic [5:0]        div;
      logic              cclk;
      logic [6:0]        bits;
      logic [7:0]        lacc;
      logic [7:0]        racc;
      logic              frame;
      logic [23:0]       lsmp;
      logic [23:0]       rsmp;
      logic              ack;
      logic [31:0]       rdata;
      logic              err;
   } sacv_state_s;

   function automatic logic [SACV_AW-1:0] sacv_addr(input logic [7:0] idx);
      return {idx, 2'b00};
   endfunction

endpackage

//--- hdl/sacv_gain.sv
`timescale 1ns/10ps
module sacv_gain
   import sacv_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // sample in
   input  wire logic                  valid_i,
   input  wire logic [SACV_SW-1:0]    sample_i,
   input  wire logic [7:0]            code_i,
   // sample out
   output logic                       valid_o,
   output logic [SACV_SW-1:0]         sample_o
);

   typedef struct packed {
      logic              vld;
      logic [23:0]       smp;
   } sacv_gain_s;

   sacv_gain_s s_q;
   sacv_gain_s s_d;

   // ==========================================================
   // 0.375 dB mantissa, 2^14 = unity; 16 steps make 6 dB
   // ==========================================================
   function automatic logic [15:0] mant(input logic [3:0] r);
      logic [15:0] m;
      m = 16'h4000;
      unique case (r)
         4'h0: m = 16'h4000;
         4'h1: m = 16'h42D2;
         4'h2: m = 16'h45C5;
         4'h3: m = 16'h48DA;
         4'h4: m = 16'h4C10;
         4'h5: m = 16'h4F6B;
         4'h6: m = 16'h52EC;
         4'h7: m = 16'h5695;
         4'h8: m = 16'h5A67;
         4'h9: m = 16'h5E64;
         4'hA: m = 16'h628E;
         4'hB: m = 16'h66E7;
         4'hC: m = 16'h6B72;
         4'hD: m = 16'h702F;
         4'hE: m = 16'h7522;
         4'hF: m = 16'h7A4D;
      endcase
      return m;
   endfunction

   logic signed [40:0] prod;
   logic signed [43:0] wide;
   logic [4:0]         rsh;

   always_comb begin
      s_d  = s_q;
      prod = $signed(sample_i) * $signed({1'b0, mant(code_i[3:0])});
      // code X: exponent X[7:4]-12 octaves, 0 dB at C0h
      rsh  = 5'(29 - int'(code_i[7:4]));
      wide = (44'(prod) <<< 3) >>> rsh; // see [RULE_06]
      s_d.vld = valid_i;
      if (valid_i) begin
         if (code_i == 8'h00) begin
            s_d.smp = 24'h000000; // see [RULE_06]
         end else if (wide > 44'sh0007FFFFF) begin
            s_d.smp = 24'h7FFFFF; // see [RULE_07]
         end else if (wide < -44'sh000800000) begin
            s_d.smp = 24'h800000;
         end else begin
            s_d.smp = wide[23:0];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign valid_o  = s_q.vld;
   assign sample_o = s_q.smp;

endmodule // sacv_gain

//--- hdl/sacv_top.sv
// Design decision made here: the APB slave port.
`timescale 1ns/10ps
module sacv_top
   import sacv_pkg::*;
(
   // clock and reset
   input  wire logic                  CLK_SYS_I,
   input  wire logic                  RST_N_I,
   // apb slave
   input  wire logic                  PSEL_I,
   input  wire logic                  PENABLE_I,
   input  wire logic                  PWRITE_I,
   input  wire logic [SACV_AW-1:0]    PADDR_I,
   input  wire logic [31:0]           PWDATA_I,
   output logic [31:0]                PRDATA_O,
   output logic                       PREADY_O,
   output logic                       PSLVERR_O,
   // modulator side
   input  wire logic                  LEFT_MOD_I,
   input  wire logic                  RIGHT_MOD_I,
   output logic                       CONV_CLK_O,
   // captured samples toward the serial interface
   output logic [SACV_SW-1:0]         CAPTURE_SERIAL_OUT_LEFT_O,
   output logic [SACV_SW-1:0]         CAPTURE_SERIAL_OUT_RIGHT_O,
   output logic                       CAPTURE_SERIAL_OUT_VALID_O
);

   sacv_state_s s_q;
   sacv_state_s s_d;

   // ==========================================================
   // helpers
   // ==========================================================

   // converter clock period in system clocks, 128x fs
   function automatic logic [5:0] period_of(input logic [2:0] ratio);
      logic [5:0] p;
      p = 6'h02;
      unique case (ratio)
         3'h0: p = 6'h02;
         3'h1: p = 6'h03;
         3'h2: p = 6'h04;
         3'h3: p = 6'h06;
         3'h4: p = 6'h08;
         3'h5: p = 6'h0C;
         3'h6: p = 6'h18;
         3'h7: p = 6'h30;
      endcase
      return p;
   endfunction

   // ones count over one frame to a signed 24-bit sample
   function automatic logic [23:0] to_sample(input logic [7:0] cnt);
      logic [7:0] v;
      v = cnt - SACV_MID;
      if (cnt >= SACV_OSR_FULL) begin
         return 24'h7FFFFF;
      end
      return {v[6:0], 17'h00000};
   endfunction

   function automatic logic hit(input logic [SACV_AW-1:0] a,
                                input logic [7:0]         idx);
      return a == sacv_addr(idx);
   endfunction

   // ==========================================================
   // combinational next state
   // ==========================================================
   logic       bus_go;
   logic       bus_done;
   logic       mapped;
   logic       wr_lvol;
   logic       wr_rvol;
   logic       commit;
   logic       tick;
   logic [5:0] period;
   logic       lbit;
   logic       rbit;

   always_comb begin
      s_d      = s_q;
      mapped   = hit(PADDR_I, SACV_IDX_CLK)  | hit(PADDR_I, SACV_IDX_LVOL) |
                 hit(PADDR_I, SACV_IDX_RVOL) | hit(PADDR_I, SACV_IDX_PWR)  |
                 hit(PADDR_I, SACV_IDX_STAT);
      // one wait state: read data is registered before pready
      bus_go   = PSEL_I & PENABLE_I & ~s_q.ack;
      bus_done = PSEL_I & PENABLE_I & s_q.ack;
      wr_lvol  = bus_done & PWRITE_I & hit(PADDR_I, SACV_IDX_LVOL);
      wr_rvol  = bus_done & PWRITE_I & hit(PADDR_I, SACV_IDX_RVOL);
      commit   = (wr_lvol | wr_rvol) & PWDATA_I[SACV_VU_BIT]; // see [RULE_09]
      period   = period_of(s_q.ratio); // see [RULE_05]
      tick     = s_q.sysen & (s_q.div >= period - 6'h01);
      lbit     = LEFT_MOD_I & s_q.len;
      rbit     = RIGHT_MOD_I & s_q.ren;

      // =======================================================
      // apb access
      // =======================================================
      s_d.ack = bus_go;
      if (bus_go) begin
         s_d.err   = ~mapped;
         s_d.rdata = 32'h00000000;
         if (!PWRITE_I) begin
            if (hit(PADDR_I, SACV_IDX_LVOL)) begin
               // update bit is write-only and reads zero
               s_d.rdata[SACV_VOL_LSB +: 8] = s_q.lvol; // see [RULE_10]
            end
            if (hit(PADDR_I, SACV_IDX_RVOL)) begin
               s_d.rdata[SACV_VOL_LSB +: 8] = s_q.rvol; // see [RULE_11]
            end
            if (hit(PADDR_I, SACV_IDX_PWR)) begin
               s_d.rdata[SACV_LEN_BIT] = s_q.len;
               s_d.rdata[SACV_REN_BIT] = s_q.ren;
            end
            if (hit(PADDR_I, SACV_IDX_CLK)) begin
               s_d.rdata[SACV_SYSEN_BIT]      = s_q.sysen;
               s_d.rdata[SACV_RATE_LSB +: 4]  = s_q.rate;
               s_d.rdata[SACV_RATIO_LSB +: 3] = s_q.ratio;
            end
            if (hit(PADDR_I, SACV_IDX_STAT)) begin
               s_d.rdata[SACV_APPL_LSB +: 8] = s_q.lapp;
               s_d.rdata[SACV_APPR_LSB +: 8] = s_q.rapp;
               s_d.rdata[SACV_PEND_BIT]      = s_q.pend;
            end
         end
      end

      // held volume only; applied gain waits for a commit
      if (wr_lvol) begin
         s_d.lvol = PWDATA_I[SACV_VOL_LSB +: 8]; // see [RULE_08]
      end
      if (wr_rvol) begin
         s_d.rvol = PWDATA_I[SACV_VOL_LSB +: 8]; // see [RULE_08]
      end
      if (bus_done && PWRITE_I && hit(PADDR_I, SACV_IDX_PWR)) begin
         s_d.len = PWDATA_I[SACV_LEN_BIT]; // see [RULE_02]
         s_d.ren = PWDATA_I[SACV_REN_BIT]; // see [RULE_02]
      end
      if (bus_done && PWRITE_I && hit(PADDR_I, SACV_IDX_CLK)) begin
         s_d.sysen = PWDATA_I[SACV_SYSEN_BIT];
         s_d.rate  = PWDATA_I[SACV_RATE_LSB +: 4];
         s_d.ratio = PWDATA_I[SACV_RATIO_LSB +: 3];
      end

      // =======================================================
      // converter clock, gated by the system clock enable
      // =======================================================
      if (!s_q.sysen) begin
         s_d.div  = 6'h00; // see [RULE_04]
         s_d.cclk = 1'b0;
      end else if (tick) begin
         s_d.div  = 6'h00;
         s_d.cclk = 1'b1;
      end else begin
         s_d.div  = s_q.div + 6'h01;
         // high for the first half period, low for the rest
         s_d.cclk = (s_q.div + 6'h01) < (period >> 1); // see [RULE_05]
      end

      // =======================================================
      // decimation: ones count over 128 modulator clocks
      // =======================================================
      s_d.frame = 1'b0;
      if (tick) begin
         s_d.bits = s_q.bits + 7'h01;
         s_d.lacc = s_q.lacc + {7'h00, lbit}; // see [RULE_01]
         s_d.racc = s_q.racc + {7'h00, rbit}; // see [RULE_01]
         if (s_q.bits == SACV_OSR_LAST) begin
            s_d.frame = 1'b1;
            s_d.lacc  = 8'h00;
            s_d.racc  = 8'h00;
            // a disabled channel delivers silence, not full scale
            s_d.lsmp  = s_q.len ? to_sample(s_q.lacc + {7'h00, lbit})
                                : 24'h000000; // see [RULE_02]
            s_d.rsmp  = s_q.ren ? to_sample(s_q.racc + {7'h00, rbit})
                                : 24'h000000; // see [RULE_02]
         end
      end
      if (!s_q.len) begin
         s_d.lacc = 8'h00;
      end
      if (!s_q.ren) begin
         s_d.racc = 8'h00;
      end

      // =======================================================
      // gain commit, both channels on one frame
      // =======================================================
      if (s_d.frame && s_q.pend) begin
         s_d.lapp = s_d.lvol; // see [RULE_12]
         s_d.rapp = s_d.rvol; // see [RULE_12]
         s_d.pend = 1'b0;
      end
      // a commit in the frame cycle stays pending; set wins
      if (commit) begin
         s_d.pend = 1'b1; // see [RULE_09]
      end
   end

   // ==========================================================
   // state register
   // ==========================================================
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         s_q      <= '0;
         s_q.lvol <= SACV_VOL_RST; // see [RULE_10]
         s_q.rvol <= SACV_VOL_RST; // see [RULE_11]
         s_q.lapp <= SACV_VOL_RST;
         s_q.rapp <= SACV_VOL_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ==========================================================
   // digital volume, one stage per channel
   // ==========================================================
   // gain and sample enter together, so a fresh gain meets
   // the first sample of its frame on both channels
   sacv_gain u_gain_left (
      .clk_i    (CLK_SYS_I),
      .rst_n_i  (RST_N_I),
      .valid_i  (s_q.frame),
      .sample_i (s_q.lsmp),
      .code_i   (s_q.lapp),
      .valid_o  (CAPTURE_SERIAL_OUT_VALID_O),
      .sample_o (CAPTURE_SERIAL_OUT_LEFT_O)
   );

   sacv_gain u_gain_right (
      .clk_i    (CLK_SYS_I),
      .rst_n_i  (RST_N_I),
      .valid_i  (s_q.frame),
      .sample_i (s_q.rsmp),
      .code_i   (s_q.rapp),
      .valid_o  (),
      .sample_o (CAPTURE_SERIAL_OUT_RIGHT_O)
   );

   // ==========================================================
   // outputs
   // ==========================================================
   assign PREADY_O   = PSEL_I & PENABLE_I & s_q.ack;
   assign PRDATA_O   = s_q.rdata;
   assign PSLVERR_O  = PREADY_O & s_q.err;
   assign CONV_CLK_O = s_q.cclk;

endmodule // sacv_top

//--- dv/sacv_top_asserts.sv
`timescale 1ns/10ps
module sacv_top_asserts
   import sacv_pkg::*;
(
   // clock and reset
   input wire logic                  CLK_SYS_I,
   input wire logic                  RST_N_I,
   // apb
   input wire logic                  PSEL_I,
   input wire logic                  PENABLE_I,
   input wire logic                  PWRITE_I,
   input wire logic [SACV_AW-1:0]    PADDR_I,
   input wire logic [31:0]           PWDATA_I,
   input wire logic [31:0]           PRDATA_O,
   input wire logic                  PREADY_O,
   input wire logic                  PSLVERR_O,
   // converter side
   input wire logic                  CONV_CLK_O,
   input wire logic [SACV_SW-1:0]    CAPTURE_SERIAL_OUT_LEFT_O,
   input wire logic [SACV_SW-1:0]    CAPTURE_SERIAL_OUT_RIGHT_O,
   input wire logic                  CAPTURE_SERIAL_OUT_VALID_O
);
   // ====================
   // shadow of the system clock and left channel enables, taken from completed writes
   // ====================
   logic sysen_q;
   logic len_q;
   wire  map_w = PADDR_I inside {10'h020, 10'h054, 10'h058, 10'h064, 10'h068};
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         sysen_q <= 1'b0;
         len_q   <= 1'b0;
      end else if (PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) begin
         if (PADDR_I == 10'h020) sysen_q <= PWDATA_I[0];
         if (PADDR_I == 10'h064) len_q <= PWDATA_I[3];
      end
   end
   default clocking @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   sequence s_setup;
      PSEL_I && !PENABLE_I;
   endsequence
   sequence s_wait_one;
      PSEL_I && PENABLE_I && !PREADY_O ##1 PREADY_O;
   endsequence
   // ====================
   // properties
   // ====================
   chk_one_wait: assert property (s_setup |=> s_wait_one)
      else $error("ready not after exactly one wait state");
   chk_ready_gated: assert property (PREADY_O |-> PSEL_I && PENABLE_I)
      else $error("ready outside access phase");
   chk_err_map: assert property (PREADY_O |-> PSLVERR_O == !map_w)
      else $error("error flag disagrees with address map");
   chk_err_rdata: assert property (PREADY_O && PSLVERR_O && !PWRITE_I |-> PRDATA_O == 32'h0)
      else $error("refused read returned data");
   chk_valid_pulse: assert property (CAPTURE_SERIAL_OUT_VALID_O |=> !CAPTURE_SERIAL_OUT_VALID_O)
      else $error("frame strobe longer than one cycle");
   chk_pair_hold: assert property (
      $changed(CAPTURE_SERIAL_OUT_LEFT_O) || $changed(CAPTURE_SERIAL_OUT_RIGHT_O)
      |-> CAPTURE_SERIAL_OUT_VALID_O)
      else $error("sample changed outside a frame strobe");
   chk_clk_gated: assert property (!sysen_q [*2] |-> !CONV_CLK_O)
      else $error("converter clock runs while disabled");
   chk_no_frames: assert property (!sysen_q [*4] |-> !CAPTURE_SERIAL_OUT_VALID_O)
      else $error("frame produced without clock enable");
   chk_left_off: assert property (
      CAPTURE_SERIAL_OUT_VALID_O && !len_q && !$past(len_q, 4)
      |-> CAPTURE_SERIAL_OUT_LEFT_O == '0)
      else $error("disabled left channel gave a sample");
endmodule // sacv_top_asserts

bind sacv_top sacv_top_asserts i_sacv_top_asserts (.CLK_SYS_I, .RST_N_I, .PSEL_I, .PENABLE_I,
   .PWRITE_I, .PADDR_I, .PWDATA_I, .PRDATA_O, .PREADY_O, .PSLVERR_O, .CONV_CLK_O,
   .CAPTURE_SERIAL_OUT_LEFT_O, .CAPTURE_SERIAL_OUT_RIGHT_O, .CAPTURE_SERIAL_OUT_VALID_O);

//--- dv/sacv_mod_model.sv
`timescale 1ns/10ps
module sacv_mod_model (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // level asked by the bench
   input  wire logic level_i,
   // bitstreams into the block
   output logic      left_o,
   output logic      right_o
);
   // a steady level gives an exact full-scale count, so gains can be checked exactly
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left_o  <= 1'b0;
         right_o <= 1'b1;
      end else begin
         left_o  <= level_i;
         right_o <= level_i;
      end
   end
endmodule // sacv_mod_model

//--- dv/stereo_adc_enable_and_volume_bench.sv
`timescale 1ns/10ps
module stereo_adc_enable_and_volume_bench;
   import sacv_pkg::*;
   logic               clk = 1'b0;
   logic               rst_n = 1'b0;
   logic               psel = 1'b0;
   logic               pen = 1'b0;
   logic               pwr = 1'b0;
   logic               lvl = 1'b1;
   logic               same = 1'b0;
   logic [SACV_AW-1:0] padr = '0;
   logic [31:0]        pwd = '0;
   logic [31:0]        prd;
   logic               rdy, err, cclk, lmod, rmod, vld;
   logic [SACV_SW-1:0] lo, ro;
   logic [32:0]        rq[$];
   logic [47:0]        sq[$];
   int                 miscompares = 0, checked = 0, seed = 22, nv = 0, c, i, n0;
   int                 pt[8] = '{2, 3, 4, 6, 8, 12, 24, 48};
   logic [31:0]        v;
   int                 nc = 0;
   logic               pc = 1'b0;
   always #12.5 clk = ~clk;
   sacv_top i_sacv_top (.CLK_SYS_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(rdy),
      .PSLVERR_O(err), .LEFT_MOD_I(lmod), .RIGHT_MOD_I(rmod), .CONV_CLK_O(cclk),
      .CAPTURE_SERIAL_OUT_LEFT_O(lo), .CAPTURE_SERIAL_OUT_RIGHT_O(ro),
      .CAPTURE_SERIAL_OUT_VALID_O(vld));
   sacv_mod_model i_sacv_mod_model (.clk_i(clk), .rst_n_i(rst_n), .level_i(lvl),
      .left_o(lmod), .right_o(rmod));
   // ====================
   // reporting
   // ====================
   task automatic fail(input string m);
      miscompares++;
      $display("mismatch at %0t: %s", $time, m);
   endtask
   task automatic wrap_up;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // ====================
   // apb master, entered just after a rising edge
   // ====================
   task automatic apb(input logic w, input logic [SACV_AW-1:0] a, input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(negedge clk);
      for (n = 0; n < 20 && rdy !== 1'b1; n++) begin
         @(posedge clk);
         @(negedge clk);
      end
      if (n >= 20) begin
         fail("no ready");
         wrap_up;
      end
      @(posedge clk);
      psel <= 1'b0;
      pen <= 1'b0;
      // one idle cycle, so a following call never reassigns psel in this step
      @(posedge clk);
   endtask
   task automatic rd(input logic [SACV_AW-1:0] a, input logic [32:0] e);
      rq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic frames(input int k, output int cyc);
      int s;
      s = nv;
      for (cyc = 0; nv < s + k && cyc < 20000; cyc++) @(posedge clk);
      if (cyc >= 20000) begin
         fail("no frame");
         wrap_up;
      end
   endtask
   // two frames let a partial frame after a change drain before the expected one
   task automatic expect_frame(input logic [23:0] l, input logic [23:0] r);
      frames(2, c);
      sq.push_back({l, r});
      frames(1, c);
   endtask
   // ====================
   // result watcher, samples at the falling edge where outputs are settled
   // ====================
   always @(negedge clk) begin
      if (rdy === 1'b1 && pwr === 1'b0 && rq.size() > 0) begin
         checked++;
         if ({err, prd} !== rq.pop_front()) fail("read data");
      end
      // converter clock rises, one per modulator tick
      if (cclk === 1'b1 && pc !== 1'b1) nc++;
      pc = cclk;
      if (vld === 1'b1) begin
         nv++;
         if (same && lo !== ro) fail("pair split");
         if (sq.size() > 0) begin
            checked++;
            if ({lo, ro} !== sq.pop_front()) fail("sample pair");
         end
      end
   end
   initial begin
      repeat (90000) @(posedge clk);
      fail("timeout");
      wrap_up;
   end
   // ====================
   // main sequence
   // ====================
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(10'h054, 33'h0_0000_00C0);
      rd(10'h058, 33'h0_0000_00C0);
      rd(10'h064, 33'h0);
      rd(10'h068, 33'h0_0000_C0C0);
      rd(10'h3FC, 33'h1_0000_0000);
      apb(1'b1, 10'h3FC, 32'hFFFF_FFFF);
      for (i = 0; i < 4; i++) begin
         v = $random(seed) & 32'hFFFF_FEFF;
         apb(1'b1, 10'h054 + 10'(4 * (i % 2)), v);
         rd(10'h054 + 10'(4 * (i % 2)), {25'h0, v[7:0]});
      end
      apb(1'b1, 10'h054, 32'h0C0);
      apb(1'b1, 10'h058, 32'h0C0);
      apb(1'b1, 10'h064, 32'h00C);
      rd(10'h064, 33'h0_0000_000C);
      repeat (600) @(posedge clk);
      checked++;
      if (nv !== 0) fail("frames while clock off");
      apb(1'b1, 10'h020, 32'h051);
      rd(10'h020, 33'h0_0000_0051);
      for (i = 0; i < 8; i++) begin
         apb(1'b1, 10'h020, {21'h0, 3'(i), 8'h01});
         frames(1, c);
         n0 = nc;
         frames(1, c);
         checked++;
         if (c !== 128 * pt[i]) fail("frame length");
         checked++;
         if (nc - n0 !== 128) fail("converter clock count");
      end
      apb(1'b1, 10'h020, 32'h001);
      expect_frame(24'h7FFFFF, 24'h7FFFFF);
      lvl <= 1'b0;
      apb(1'b1, 10'h054, 32'h1FF);
      apb(1'b1, 10'h058, 32'h1FF);
      expect_frame(24'h800000, 24'h800000);
      lvl <= 1'b1;
      apb(1'b1, 10'h054, 32'h000);
      apb(1'b1, 10'h058, 32'h000);
      expect_frame(24'h7FFFFF, 24'h7FFFFF);
      rd(10'h068, 33'h0_0000_FFFF);
      same <= 1'b1;
      apb(1'b1, 10'h058, 32'h100);
      expect_frame(24'h0, 24'h0);
      rd(10'h068, 33'h0);
      apb(1'b1, 10'h054, 32'h0C0);
      apb(1'b1, 10'h058, 32'h1C0);
      expect_frame(24'h7FFFFF, 24'h7FFFFF);
      same <= 1'b0;
      apb(1'b1, 10'h054, 32'h100);
      // let the mute reach the applied gain before the enable is cleared
      frames(1, c);
      apb(1'b1, 10'h064, 32'h004);
      expect_frame(24'h0, 24'h7FFFFF);
      apb(1'b1, 10'h020, 32'h000);
      repeat (8) @(posedge clk);
      n0 = nv;
      repeat (600) @(posedge clk);
      checked++;
      if (nv !== n0) fail("frames after clock off");
      wrap_up;
   end
endmodule // stereo_adc_enable_and_volume_bench
